// ### hw/ddr_mode_pkg.sv
package ddr_mode_pkg;

   localparam int DQ_W = 8;
   localparam int MODE_W = 13;
   localparam int WBUF_DEPTH = 16;
   localparam int DLL_BIT = 8;
   localparam int BT_BIT = 3;
   localparam int AP_BIT = 10;
   localparam logic [12:0] MODE_RST = 13'h0021;
   localparam logic [2:0] BL_4 = 3'h2;
   localparam logic [2:0] BL_8 = 3'h3;
   localparam logic [2:0] RL_25 = 3'h6;
   localparam logic [2:0] HALF_RL2 = 3'h4;
   localparam logic [2:0] HALF_RL25 = 3'h5;
   localparam logic [1:0] SEL_MODE = 2'h0;
   localparam logic [1:0] SEL_EXT = 2'h1;
   localparam logic [2:0] OP_ACT = 3'h3;
   localparam logic [2:0] OP_RD = 3'h5;
   localparam logic [2:0] OP_WR = 3'h4;
   localparam logic [2:0] OP_PRE = 3'h2;
   localparam logic [2:0] OP_MRS = 3'h0;
   localparam logic [3:0] SPD_DEV_ID = 4'ha;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   // Arbitrary fill pattern for the factory half
   localparam logic [7:0] SPD_SEED = 8'h3c;

   typedef struct packed {
      logic rank0_select_n;
      logic rank1_select_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic bank_select_high;
      logic bank_select_low;
      logic [12:0] row_col_addr_lines;
   } ddr_cmd_t;

   typedef struct packed {
      logic [1:0] bank;
      logic [2:0] col_a;
      logic [2:0] col_b;
      logic [1:0] mask;
      logic [15:0] data;
   } wr_item_t;

   typedef enum logic [6:0] {
      I_IDLE = 7'h01,
      I_DEV = 7'h02,
      I_WORD = 7'h04,
      I_DATA = 7'h08,
      I_ACK = 7'h10,
      I_SEND = 7'h20,
      I_RACK = 7'h40
   } i2c_st_t;

   function automatic logic [3:0] burst_len(input logic [2:0] code);
      case (code)
         BL_4: burst_len = 4'h4;
         BL_8: burst_len = 4'h8;
         default: burst_len = 4'h2;
      endcase
   endfunction

   function automatic logic [2:0] burst_col(input logic [2:0] start,
      input logic [2:0] idx, input logic [3:0] len, input logic ilv);
      logic [2:0] msk;
      logic [2:0] off;
      msk = 3'(len - 4'h1);
      off = ilv ? (start ^ idx) : 3'(start + idx);
      burst_col = (start & ~msk) | (off & msk);
   endfunction

   function automatic logic [7:0] spd_factory(input logic [7:0] a);
      spd_factory = a ^ SPD_SEED;
   endfunction

endpackage

// ### hw/wbuf_fifo.sv
`timescale 1ns/1ps
module wbuf_fifo #(
   parameter int WIDTH = 26,
   parameter int DEPTH = 16
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } fifo_t;

   fifo_t s_r;
   fifo_t s_nxt;
   logic push;
   logic pop;

   // ----------------------------------------
   // Handshake
   // ----------------------------------------
   assign in_ready_o = (s_r.cnt != (AW+1)'(DEPTH));
   assign out_valid_o = (s_r.cnt != '0);
   assign out_data_o = s_r.mem[s_r.rp];
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;

   always_comb
   begin
      s_nxt = s_r;
      if (push)
      begin
         s_nxt.mem[s_r.wp] = in_data_i;
         s_nxt.wp = AW'(s_r.wp + 1'b1);
      end
      if (pop)
      begin
         s_nxt.rp = AW'(s_r.rp + 1'b1);
      end
      s_nxt.cnt = (AW+1)'(s_r.cnt + push - pop);
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s_r <= '0;
      end
      else if (ce_i)
      begin
         s_r <= s_nxt;
      end
   end

endmodule

// ### hw/ddr_mode_register_burst.sv
`timescale 1ns/1ps
module ddr_mode_register_burst (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic ck_i,
   input wire logic clock_complement_i,
   input wire ddr_mode_pkg::ddr_cmd_t cmd_i,
   input wire logic [ddr_mode_pkg::DQ_W-1:0] dq_i,
   output logic [ddr_mode_pkg::DQ_W-1:0] dq_o,
   output logic dq_oe_o,
   input wire logic dm_i,
   input wire logic dqs_i,
   output logic dqs_o,
   output logic dqs_oe_o,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic [2:0] presence_addr_straps_i,
   output logic [ddr_mode_pkg::MODE_W-1:0] mode_config_o,
   output logic dll_reset_o,
   output logic [3:0] bank_open_o,
   output logic wbuf_ready_o
);
   import ddr_mode_pkg::*;

   typedef struct packed {
      logic [1:0] ck_s;
      logic [1:0] ckn_s;
      logic ck_ph;
      ddr_cmd_t cmd_s1;
      ddr_cmd_t cmd_s2;
      logic [1:0][7:0] dq_s;
      logic [1:0] dm_s;
      logic [1:0] dqs_s;
      logic dqs_prev;
      logic [1:0][1:0] i2_s;
      logic [1:0] i2_prev;
      logic [1:0][2:0] sa_s;
      logic [12:0] mode;
      logic [3:0] open;
      logic [2:0] rd_wait;
      logic rd_act;
      logic [3:0] rd_idx;
      logic [1:0] rd_bank;
      logic [2:0] rd_start;
      logic rd_ap;
      logic [7:0] dq_out;
      logic [7:0] pre;
      logic dq_oe;
      logic dqs_out;
      logic dqs_oe;
      logic wr_act;
      logic [3:0] wr_idx;
      logic [1:0] wr_bank;
      logic [2:0] wr_start;
      logic wr_ap;
      logic [7:0] wr_lo;
      logic wr_m0;
      logic wpush;
      wr_item_t witem;
      logic [31:0][7:0] arr;
      logic [127:0][7:0] spd;
      i2c_st_t i2;
      i2c_st_t after;
      logic [3:0] bitc;
      logic [7:0] sh;
      logic [7:0] ptr;
      logic sda_low;
      logic rack_ok;
   } st_t;

   st_t s_r;
   st_t s_nxt;
   ddr_cmd_t c;
   logic [2:0] op;
   logic [1:0] bank;
   logic ck_hi, ck_lo, ck_rise, ck_fall, ck_edge;
   logic sel, cmd_ok, is_mrs, desel, cl25, ilv, launch0, rd_end;
   logic [3:0] blen;
   logic scl, sda, scl_rise, scl_fall, i2_start, i2_stop, addr_hit;
   logic spd_load, spd_wr;
   logic [7:0] spd_byte;
   logic arr_busy, pop;
   wr_item_t wq;

   // ----------------------------------------
   // Clock crossing and command decode
   // ----------------------------------------
   assign ck_hi = s_r.ck_s[1] & ~s_r.ckn_s[1];
   assign ck_lo = ~s_r.ck_s[1] & s_r.ckn_s[1];
   assign ck_rise = ck_hi & ~s_r.ck_ph;
   assign ck_fall = ck_lo & s_r.ck_ph;
   assign ck_edge = ck_rise | ck_fall;
   assign c = s_r.cmd_s2;
   assign op = {c.ras_n, c.cas_n, c.we_n};
   assign bank = {c.bank_select_high, c.bank_select_low};
   assign sel = ~(c.rank0_select_n & c.rank1_select_n);
   assign desel = ck_rise & ~sel;
   assign cmd_ok = ck_rise & sel;
   assign is_mrs = cmd_ok && op == OP_MRS && bank == SEL_MODE;
   assign blen = burst_len(s_r.mode[2:0]);
   assign ilv = s_r.mode[BT_BIT];
   assign cl25 = (s_r.mode[6:4] == RL_25);
   assign launch0 = ck_edge && s_r.rd_wait == 3'h1;
   assign rd_end = ck_edge && s_r.rd_act && s_r.rd_idx == blen;
   // Array port is shared; drain waits while a read fetches
   assign arr_busy = ck_edge & (s_r.rd_wait != 3'h0 | s_r.rd_act);

   // ----------------------------------------
   // Presence-detect decode
   // ----------------------------------------
   assign scl = s_r.i2_s[1][1];
   assign sda = s_r.i2_s[1][0];
   assign scl_rise = scl & ~s_r.i2_prev[1];
   assign scl_fall = ~scl & s_r.i2_prev[1];
   assign i2_start = scl & s_r.i2_prev[1] & s_r.i2_prev[0] & ~sda;
   assign i2_stop = scl & s_r.i2_prev[1] & ~s_r.i2_prev[0] & sda;
   assign addr_hit = (s_r.sh[7:1] == {SPD_DEV_ID, s_r.sa_s[1]});
   assign spd_byte = s_r.ptr[7] ? s_r.spd[s_r.ptr[6:0]]
                                : spd_factory(s_r.ptr);
   assign spd_load = scl_fall && ((s_r.i2 == I_ACK && s_r.after == I_SEND)
                     || (s_r.i2 == I_RACK && s_r.rack_ok));
   assign spd_wr = scl_fall && s_r.i2 == I_DATA && s_r.bitc == BYTE_BITS;

   wbuf_fifo #(
      .WIDTH($bits(wr_item_t)),
      .DEPTH(WBUF_DEPTH)
   ) u_wbuf (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .in_valid_i(s_r.wpush),
      .in_ready_o(wbuf_ready_o),
      .in_data_i(s_r.witem),
      .out_valid_o(pop),
      .out_ready_i(~arr_busy),
      .out_data_o(wq)
   );

   always_comb
   begin
      s_nxt = s_r;
      s_nxt.ck_s = {s_r.ck_s[0], ck_i};
      s_nxt.ckn_s = {s_r.ckn_s[0], clock_complement_i};
      s_nxt.cmd_s1 = cmd_i;
      s_nxt.cmd_s2 = s_r.cmd_s1;
      s_nxt.dq_s = {s_r.dq_s[0], dq_i};
      s_nxt.dm_s = {s_r.dm_s[0], dm_i};
      s_nxt.dqs_s = {s_r.dqs_s[0], dqs_i};
      s_nxt.dqs_prev = s_r.dqs_s[1];
      s_nxt.i2_s = {s_r.i2_s[0], {scl_i, sda_i}};
      s_nxt.i2_prev = s_r.i2_s[1];
      s_nxt.sa_s = {s_r.sa_s[0], presence_addr_straps_i};
      s_nxt.wpush = 1'b0;
      s_nxt.mode[DLL_BIT] = 1'b0;
      if (ck_rise)
         s_nxt.ck_ph = 1'b1;
      if (ck_fall)
         s_nxt.ck_ph = 1'b0;
      // Commands; mode load never touches the array
      if (is_mrs)
         s_nxt.mode = c.row_col_addr_lines;
      if (cmd_ok && op == OP_PRE)
      begin
         if (c.row_col_addr_lines[AP_BIT])
            s_nxt.open = 4'h0;
         else
            s_nxt.open[bank] = 1'b0;
      end
      if (cmd_ok && op == OP_RD)
      begin
         s_nxt.rd_wait = cl25 ? HALF_RL25 : HALF_RL2;
         s_nxt.rd_act = 1'b0;
         s_nxt.rd_bank = bank;
         s_nxt.rd_start = c.row_col_addr_lines[2:0];
         s_nxt.rd_ap = c.row_col_addr_lines[AP_BIT];
      end
      if (cmd_ok && op == OP_WR)
      begin
         s_nxt.wr_act = 1'b1;
         s_nxt.wr_idx = 4'h0;
         s_nxt.wr_bank = bank;
         s_nxt.wr_start = c.row_col_addr_lines[2:0];
         s_nxt.wr_ap = c.row_col_addr_lines[AP_BIT];
      end
      // ----------------------------------------
      // Read launch on both clock crossings
      // ----------------------------------------
      if (ck_edge && s_r.rd_wait != 3'h0)
      begin
         s_nxt.rd_wait = s_r.rd_wait - 3'h1;
         if (s_r.rd_wait == 3'h2)
         begin
            s_nxt.dqs_oe = 1'b1;
            s_nxt.dqs_out = 1'b0;
         end
      end
      if (launch0 || (ck_edge && s_r.rd_act && !rd_end))
      begin
         if (launch0)
            s_nxt.rd_idx = 4'h1;
         else
            s_nxt.rd_idx = s_r.rd_idx + 4'h1;
         s_nxt.rd_act = 1'b1;
         s_nxt.dq_oe = 1'b1;
         s_nxt.dqs_out = ~s_r.rd_idx[0] | launch0;
         // Prefetch: two columns per clock from the array
         if (launch0 || !s_r.rd_idx[0])
         begin
            s_nxt.dq_out = s_r.arr[{s_r.rd_bank, burst_col(s_r.rd_start,
               launch0 ? 3'h0 : s_r.rd_idx[2:0], blen, ilv)}];
            s_nxt.pre = s_r.arr[{s_r.rd_bank, burst_col(s_r.rd_start,
               launch0 ? 3'h1 : s_r.rd_idx[2:0] + 3'h1, blen, ilv)}];
         end
         else
            s_nxt.dq_out = s_r.pre;
      end
      if (rd_end)
      begin
         s_nxt.rd_act = 1'b0;
         s_nxt.dq_oe = 1'b0;
         s_nxt.dqs_oe = 1'b0;
         if (s_r.rd_ap)
            s_nxt.open[s_r.rd_bank] = 1'b0;
      end
      // ----------------------------------------
      // Write capture on both strobe edges
      // ----------------------------------------
      if (s_r.wr_act && s_r.dqs_s[1] != s_r.dqs_prev)
      begin
         s_nxt.wr_idx = s_r.wr_idx + 4'h1;
         if (!s_r.wr_idx[0])
         begin
            s_nxt.wr_lo = s_r.dq_s[1];
            s_nxt.wr_m0 = s_r.dm_s[1];
         end
         else
         begin
            s_nxt.wpush = 1'b1;
            s_nxt.witem.bank = s_r.wr_bank;
            s_nxt.witem.col_a = burst_col(s_r.wr_start,
               {s_r.wr_idx[2:1], 1'b0}, blen, ilv);
            s_nxt.witem.col_b = burst_col(s_r.wr_start,
               s_r.wr_idx[2:0], blen, ilv);
            s_nxt.witem.mask = {s_r.dm_s[1], s_r.wr_m0};
            s_nxt.witem.data = {s_r.dq_s[1], s_r.wr_lo};
         end
         if (s_r.wr_idx + 4'h1 == blen)
         begin
            s_nxt.wr_act = 1'b0;
            if (s_r.wr_ap)
               s_nxt.open[s_r.wr_bank] = 1'b0;
         end
      end
      if (pop && !arr_busy)
      begin
         if (!wq.mask[0])
            s_nxt.arr[{wq.bank, wq.col_a}] = wq.data[7:0];
         if (!wq.mask[1])
            s_nxt.arr[{wq.bank, wq.col_b}] = wq.data[15:8];
      end
      // Activate wins over a same-cycle auto precharge
      if (cmd_ok && op == OP_ACT)
         s_nxt.open[bank] = 1'b1;
      // ----------------------------------------
      // Presence-detect slave
      // ----------------------------------------
      if (i2_start)
      begin
         s_nxt.i2 = I_DEV;
         s_nxt.bitc = 4'h0;
         s_nxt.sda_low = 1'b0;
      end
      else if (i2_stop)
      begin
         s_nxt.i2 = I_IDLE;
         s_nxt.sda_low = 1'b0;
      end
      else
      begin
         case (s_r.i2)
            I_IDLE:
               s_nxt.i2 = I_IDLE;
            I_DEV, I_WORD, I_DATA:
               if (scl_rise && s_r.bitc != BYTE_BITS)
               begin
                  s_nxt.sh = {s_r.sh[6:0], sda};
                  s_nxt.bitc = s_r.bitc + 4'h1;
               end
               else if (scl_fall && s_r.bitc == BYTE_BITS)
               begin
                  s_nxt.bitc = 4'h0;
                  s_nxt.i2 = I_ACK;
                  s_nxt.sda_low = 1'b1;
                  s_nxt.after = I_DATA;
                  if (s_r.i2 == I_DEV)
                  begin
                     s_nxt.after = s_r.sh[0] ? I_SEND : I_WORD;
                     if (!addr_hit)
                     begin
                        s_nxt.i2 = I_IDLE;
                        s_nxt.sda_low = 1'b0;
                     end
                  end
                  else if (s_r.i2 == I_WORD)
                     s_nxt.ptr = s_r.sh;
                  else
                  begin
                     // Factory half is read-only
                     if (s_r.ptr[7])
                        s_nxt.spd[s_r.ptr[6:0]] = s_r.sh;
                     s_nxt.ptr = s_r.ptr + 8'h01;
                  end
               end
            I_ACK:
               if (scl_fall)
               begin
                  s_nxt.sda_low = 1'b0;
                  s_nxt.i2 = s_r.after;
               end
            I_SEND:
               if (scl_fall)
               begin
                  if (s_r.bitc == BYTE_BITS)
                  begin
                     s_nxt.sda_low = 1'b0;
                     s_nxt.i2 = I_RACK;
                  end
                  else
                  begin
                     s_nxt.sh = {s_r.sh[6:0], 1'b0};
                     s_nxt.sda_low = ~s_r.sh[6];
                     s_nxt.bitc = s_r.bitc + 4'h1;
                  end
               end
            I_RACK:
               if (scl_rise)
               begin
                  s_nxt.rack_ok = ~sda;
                  if (sda)
                     s_nxt.i2 = I_IDLE;
               end
            default:
               s_nxt.i2 = I_IDLE;
         endcase
         if (spd_load)
         begin
            s_nxt.sh = spd_byte;
            s_nxt.sda_low = ~spd_byte[7];
            s_nxt.ptr = s_r.ptr + 8'h01;
            s_nxt.bitc = 4'h1;
            s_nxt.i2 = I_SEND;
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s_r <= '0;
         s_r.mode <= MODE_RST;
         s_r.i2 <= I_IDLE;
         s_r.after <= I_IDLE;
         // Idle bus level, so no false edge follows reset
         s_r.i2_s <= '1;
         s_r.i2_prev <= '1;
      end
      else if (ce_i)
      begin
         s_r <= s_nxt;
      end
   end

   assign dq_o = s_r.dq_out;
   assign dq_oe_o = s_r.dq_oe;
   assign dqs_o = s_r.dqs_out;
   assign dqs_oe_o = s_r.dqs_oe;
   assign sda_o = 1'b0;
   assign sda_oe_o = s_r.sda_low;
   assign mode_config_o = s_r.mode;
   assign dll_reset_o = s_r.mode[DLL_BIT];
   assign bank_open_o = s_r.open;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i || !ce_i);

   mode_load_a: assert property (is_mrs |=> s_r.mode[7:0] ==
      $past(c.row_col_addr_lines[7:0]) && s_r.mode[12:9] ==
      $past(c.row_col_addr_lines[12:9]))
      else $error("mode register not loaded");
   dll_pulse_a: assert property (is_mrs && c.row_col_addr_lines[DLL_BIT]
      |=> dll_reset_o ##1 !dll_reset_o)
      else $error("dll reset bit did not self-clear");
   desel_ignore_a: assert property (desel |=>
      $stable(s_r.mode[7:0]) && !$rose(s_r.wr_act))
      else $error("command taken while deselected");
   cmd_rise_a: assert property (cmd_ok |-> s_r.ck_s[1] &&
      !s_r.ckn_s[1] && !s_r.ck_ph)
      else $error("command outside rising crossing");
   first_cl2_a: assert property (launch0 && !cl25 |-> ck_rise)
      else $error("latency 2 launch not on rising crossing");
   first_half_a: assert property (launch0 && cl25 |-> ck_fall)
      else $error("latency 2.5 launch not on falling crossing");
   dq_edge_a: assert property ($changed(s_r.dq_out) |->
      $past(ck_edge) && s_r.dq_oe && s_r.dqs_oe)
      else $error("read data moved off a clock crossing");
   auto_pre_a: assert property (rd_end && s_r.rd_ap && !cmd_ok |=>
      !s_r.open[$past(s_r.rd_bank)])
      else $error("auto precharge did not close row");
   addr_miss_a: assert property (scl_fall && s_r.i2 == I_DEV &&
      s_r.bitc == BYTE_BITS && !addr_hit && !i2_start && !i2_stop
      |=> s_r.i2 == I_IDLE && !sda_oe_o)
      else $error("acknowledged a foreign address");
   spd_lock_a: assert property (spd_wr && !s_r.ptr[7] |=>
      $stable(s_r.spd))
      else $error("factory half written");

   cover property (launch0 && cl25);
   cover property (is_mrs && c.row_col_addr_lines[DLL_BIT]);
   cover property (pop && !arr_busy && s_r.wr_ap);
   cover property (s_r.i2 == I_SEND ##1 s_r.i2 == I_RACK);

endmodule

// ### dv/mem_ctrl_model.sv
`timescale 1ns/1ps
module mem_ctrl_model (
   input wire logic clk_i,
   output logic ck_o,
   output logic ck_n_o,
   output ddr_mode_pkg::ddr_cmd_t cmd_o,
   output logic [7:0] dq_o,
   output logic dm_o,
   output logic dqs_o
);
   import ddr_mode_pkg::*;
   // ----------------------------------------
   // Differential clock, free running
   // ----------------------------------------
   initial
   begin
      ck_o = 1'b0;
      cmd_o = '1;
      dq_o = 8'h5a;
      dm_o = 1'b0;
      dqs_o = 1'b0;
   end
   always #40 ck_o = ~ck_o;
   assign ck_n_o = ~ck_o;
   // ----------------------------------------
   // Command and write strobe drivers
   // ----------------------------------------
   // Setup of half a ck period hides the 2 FF sync in the device
   task automatic send(input ddr_cmd_t c);
      @(negedge ck_o);
      @(posedge clk_i);
      cmd_o <= c;
      @(posedge ck_o);
      repeat (6) @(posedge clk_i);
      // Released bus: deselected, other lines inverted
      cmd_o <= {2'h3, ~c[17:0]};
   endtask
   task automatic burst(input logic [31:0] d, input logic [3:0] m);
      int i;
      for (i = 0; i < 4; i++)
      begin
         @(posedge clk_i);
         dq_o <= d[8*i +: 8];
         dm_o <= m[i];
         repeat (4) @(posedge clk_i);
         dqs_o <= ~dqs_o;
         repeat (4) @(posedge clk_i);
      end
      dq_o <= ~d[31:24];
      dm_o <= 1'b1;
   endtask
endmodule

// ### dv/ddr_mode_register_burst_test.sv
`timescale 1ns/1ps
module ddr_mode_register_burst_test;
   import ddr_mode_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic ck, ck_n, dm, dqs, dq_oe, dqs_d, dqs_oe, sda_d, sda_oe, dll;
   logic dqs_w, sda_w, wb_rdy;
   logic scl = 1'b1;
   logic sda_m = 1'b1;
   logic [7:0] dq, rd_q, dq_w;
   logic [12:0] mode_q;
   logic [3:0] banks;
   ddr_cmd_t cmd;
   int err_total = 0;
   int checks = 0;
   always #2.5 clk_i = ~clk_i;
   // ----------------------------------------
   // Wire resolution and instances
   // ----------------------------------------
   assign dq_w = dq_oe ? rd_q : dq;
   assign dqs_w = dqs_oe ? dqs_d : dqs;
   assign sda_w = (sda_oe ? sda_d : 1'b1) & sda_m;
   mem_ctrl_model ctrl_u (.clk_i(clk_i), .ck_o(ck), .ck_n_o(ck_n),
      .cmd_o(cmd), .dq_o(dq), .dm_o(dm), .dqs_o(dqs));
   ddr_mode_register_burst dut_u (.clk_i(clk_i), .rst_i(rst_i),
      .ce_i(1'b1), .ck_i(ck), .clock_complement_i(ck_n), .cmd_i(cmd),
      .dq_i(dq_w), .dq_o(rd_q), .dq_oe_o(dq_oe), .dm_i(dm),
      .dqs_i(dqs_w), .dqs_o(dqs_d), .dqs_oe_o(dqs_oe), .scl_i(scl),
      .sda_i(sda_w), .sda_o(sda_d), .sda_oe_o(sda_oe),
      .presence_addr_straps_i(3'h5), .mode_config_o(mode_q),
      .dll_reset_o(dll), .bank_open_o(banks), .wbuf_ready_o(wb_rdy));
   // ----------------------------------------
   // Shared helpers
   // ----------------------------------------
   task automatic final_report();
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic check(input string what, input logic [15:0] exp,
      input logic [15:0] seen);
      checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   function automatic ddr_cmd_t mk(input logic [2:0] op,
      input logic [1:0] ba, input logic [12:0] a);
      mk = {2'h1, op, ba, a};
   endfunction
   // Read of four words; half is the latency in half ck periods
   task automatic rd(input logic [12:0] col, input int half,
      input logic [31:0] exp);
      int n;
      int k;
      int lat;
      logic last;
      n = 0;
      k = 0;
      lat = 0;
      last = 1'b0;
      ctrl_u.send(mk(OP_RD, 2'h1, col));
      while (k < 4 && n < 200)
      begin
         @(posedge clk_i);
         #1;
         n++;
         if (dqs_oe === 1'b1 && dq_oe === 1'b1 && dqs_d !== last)
         begin
            if (k == 0)
               lat = n;
            check("read word", 16'(exp[8*k +: 8]), 16'(rd_q));
            last = dqs_d;
            k++;
         end
      end
      if (k < 4)
      begin
         err_total++;
         $display("mismatch read words expected 4 seen %0d", k);
         final_report();
      end
      // Six clk already spent in send, about three in sync and launch
      check("read latency", 16'h1,
         16'(lat >= half * 8 - 5 && lat <= half * 8 - 1));
   endtask
   // Eight clk_i per scl phase, well above the sync floor
   task automatic i2_set(input logic c, input logic d);
      @(posedge clk_i);
      scl <= c;
      sda_m <= d;
      repeat (7) @(posedge clk_i);
   endtask
   // Nine scl periods: eight bits MSB first, then the acknowledge
   task automatic i2_byte(input logic [8:0] tx, output logic [8:0] rx);
      int b;
      for (b = 8; b >= 0; b--)
      begin
         i2_set(1'b0, tx[b]);
         i2_set(1'b1, tx[b]);
         #1;
         rx[b] = sda_w;
      end
   endtask
   task automatic i2_start();
      i2_set(1'b0, 1'b1);
      i2_set(1'b1, 1'b1);
      i2_set(1'b1, 1'b0);
   endtask
   task automatic i2_stop();
      i2_set(1'b0, 1'b0);
      i2_set(1'b1, 1'b0);
      i2_set(1'b1, 1'b1);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_mode();
      int hi;
      hi = 0;
      fork
         ctrl_u.send(mk(OP_MRS, SEL_MODE, 13'h0122));
         repeat (48)
         begin
            @(posedge clk_i);
            #1;
            if (dll === 1'b1)
               hi++;
         end
      join
      check("dll pulse", 16'h1, 16'(hi));
      check("mode load", 16'h0022, 16'(mode_q));
      ctrl_u.send(mk(OP_MRS, SEL_MODE, 13'h0022));
      check("normal reload", 16'h0022, 16'(mode_q));
      ctrl_u.send(mk(OP_MRS, SEL_EXT, 13'h0075));
      check("ext load", 16'h0022, 16'(mode_q));
      ctrl_u.send({2'h3, OP_MRS, SEL_MODE, 13'h0075});
      check("deselect", 16'h0022, 16'(mode_q));
   endtask
   task automatic t_write();
      ctrl_u.send(mk(OP_ACT, 2'h1, 13'h1abc));
      check("bank open", 16'h2, 16'(banks));
      ctrl_u.send(mk(OP_WR, 2'h1, 13'h0400));
      ctrl_u.burst(32'hd4c3b2a1, 4'h4);
      repeat (40) @(posedge clk_i);
      check("auto precharge", 16'h0, 16'(banks));
   endtask
   task automatic t_read_seq();
      ctrl_u.send(mk(OP_ACT, 2'h1, 13'h0123));
      rd(13'h0403, 4, 32'h00b2a1d4);
      ctrl_u.send(mk(OP_ACT, 2'h2, 13'h0123));
      check("read auto precharge", 16'h4, 16'(banks));
      ctrl_u.send(mk(OP_PRE, 2'h0, 13'h0400));
      check("precharge all", 16'h0, 16'(banks));
   endtask
   task automatic t_read_ilv();
      ctrl_u.send(mk(OP_MRS, SEL_MODE, 13'h006a));
      check("mode reload", 16'h006a, 16'(mode_q));
      ctrl_u.send(mk(OP_ACT, 2'h1, 13'h0042));
      // Reload kept the array: same bytes in interleaved order
      rd(13'h0001, 5, 32'h00d4a1b2);
      ctrl_u.send(mk(OP_ACT, 2'h2, 13'h0042));
      ctrl_u.send(mk(OP_PRE, 2'h1, 13'h0000));
      check("precharge one", 16'h4, 16'(banks));
   endtask
   // Upper half keeps system bytes, lower half ignores writes
   task automatic t_spd();
      logic [8:0] rx;
      logic [8:0] dev;
      dev = {SPD_DEV_ID, 3'h5, 2'h1};
      i2_start();
      i2_byte(dev, rx);
      check("spd addr ack", 16'h0, 16'(rx[0]));
      i2_byte({8'h7f, 1'b1}, rx);
      i2_byte({8'h11, 1'b1}, rx);
      check("spd lower write ack", 16'h0, 16'(rx[0]));
      i2_byte({8'h22, 1'b1}, rx);
      i2_stop();
      i2_start();
      i2_byte(dev, rx);
      i2_byte({8'h7f, 1'b1}, rx);
      i2_start();
      i2_byte(dev | 9'h002, rx);
      i2_byte(9'h1fe, rx);
      check("spd factory byte", 16'(8'h7f ^ SPD_SEED), 16'(rx[8:1]));
      i2_byte(9'h1ff, rx);
      check("spd system byte", 16'h0022, 16'(rx[8:1]));
      i2_stop();
      i2_start();
      i2_byte({SPD_DEV_ID, 3'h2, 2'h1}, rx);
      check("spd foreign addr", 16'h1, 16'(rx[0]));
      i2_stop();
   endtask
   // ----------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------
   initial
   begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      #1;
      check("reset mode", 16'h0021, 16'(mode_q));
      check("reset strobe oe", 16'h0, 16'(dqs_oe));
      check("reset buffer ready", 16'h1, 16'(wb_rdy));
      t_mode();
      t_write();
      t_read_seq();
      t_read_ilv();
      t_spd();
      final_report();
   end
   initial
   begin
      repeat (100000) @(posedge clk_i);
      err_total++;
      $display("mismatch watchdog expected done seen hang");
      final_report();
   end
endmodule
